// [src/sbl_loader.sv]
// Purpose: serial and parallel bootstrap loader engine
// Assumes: memory read data is combinational, sampled on the edge after the address
// Notes:   straps are sampled after reset release, once
module sbl_loader
  import sbl_pkg::*;
#(
  parameter int          PROG_CNT = sbl_pkg::PROG_CYCLES,
  parameter logic [15:0] RAM_BASE = sbl_pkg::RAM_BASE_DEF,
  parameter logic [15:0] RAM_TOP  = sbl_pkg::RAM_TOP_DEF
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // mode straps and stop pin
  input  wire logic        mode_select_bit_three,
  input  wire logic        mode_select_bit_four,
  input  wire logic        load_stop_pin,
  // serial link
  input  wire logic        rxd,
  output logic             txd_q,
  // parallel source
  input  wire logic [7:0]  par_data,
  input  wire logic        handshake_in_pin,
  output logic             handshake_out_pin_q,
  output logic [15:0]      par_addr_q,
  // memory array port
  input  wire logic [7:0]  mem_rdata,
  output logic [15:0]      mem_addr_q,
  output logic [7:0]       mem_wdata_q,
  output logic             eprom_we_q,
  output logic             ram_we_q,
  output logic             program_latch_enable_q,
  output logic             program_enable_q,
  // status and execution
  output logic             red_led_q,
  output logic             exec_valid_q,
  output logic [15:0]      exec_addr_q,
  // interrupt vector redirection
  input  wire logic [2:0]  vec_idx,
  output logic             pseudo_vec_active_q,
  output logic [15:0]      vec_target_q
);
  import sbl_pkg::*;

  if (PROG_CNT < 1 || RAM_TOP < RAM_BASE + STACK_BYTES) begin : g_chk
    $error("loader parameters out of range");
  end

  typedef enum logic [1:0] {SBL_RX_IDLE, SBL_RX_START, SBL_RX_DATA, SBL_RX_STOP} sbl_rx_t;
  typedef enum logic [3:0] {SBL_BOOT, SBL_INIT, SBL_NEXT, SBL_TX, SBL_RX, SBL_END,
                            SBL_PREQ, SBL_PACK, SBL_PREL, SBL_EXEC, SBL_HALT} sbl_st_t;
  typedef enum logic [2:0] {SBL_E_IDLE, SBL_E_LATCH, SBL_E_WR, SBL_E_PGM,
                            SBL_E_CLR, SBL_E_RA, SBL_E_RD} sbl_eng_t;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] rx_s_q, m3_s_q, m4_s_q, stop_s_q, hs_s_q;
  logic [7:0] pd_s1_q, pd_s2_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rx_s_q   <= 2'h3;
      m3_s_q   <= 2'h0;
      m4_s_q   <= 2'h0;
      stop_s_q <= 2'h3;
      hs_s_q   <= 2'h0;
      pd_s1_q  <= 8'h00;
      pd_s2_q  <= 8'h00;
    end
    else
    begin
      rx_s_q   <= {rx_s_q[0], rxd};
      m3_s_q   <= {m3_s_q[0], mode_select_bit_three};
      m4_s_q   <= {m4_s_q[0], mode_select_bit_four};
      stop_s_q <= {stop_s_q[0], load_stop_pin};
      hs_s_q   <= {hs_s_q[0], handshake_in_pin};
      pd_s1_q  <= par_data;
      pd_s2_q  <= pd_s1_q;
    end
  end

  // -----------------------------------------------------------------
  // serial receiver
  // -----------------------------------------------------------------
  sbl_rx_t    rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_push_q;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [7:0] fifo_out_data;

  // a held byte blocks the next start bit: overflow stalls, never overwrites
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rx_st_q   <= SBL_RX_IDLE;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_push_q <= 1'b0;
    end
    else
    begin
      if (rx_push_q && fifo_in_ready)
      begin
        rx_push_q <= 1'b0;
      end
      unique case (rx_st_q)
        SBL_RX_IDLE:
        begin
          if (!rx_push_q && !rx_s_q[1])
          begin
            rx_st_q  <= SBL_RX_START;
            rx_cnt_q <= 16'(HALF_BIT);
          end
        end
        SBL_RX_START:
        begin
          if (rx_cnt_q == 16'h0000)
          begin
            rx_st_q  <= rx_s_q[1] ? SBL_RX_IDLE : SBL_RX_DATA;
            rx_cnt_q <= 16'(BIT_CYCLES - 1);
            rx_bit_q <= 3'h0;
          end
          else
          begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end
        end
        SBL_RX_DATA:
        begin
          if (rx_cnt_q == 16'h0000)
          begin
            rx_sh_q  <= {rx_s_q[1], rx_sh_q[7:1]};
            rx_cnt_q <= 16'(BIT_CYCLES - 1);
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
            begin
              rx_st_q <= SBL_RX_STOP;
            end
          end
          else
          begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end
        end
        SBL_RX_STOP:
        begin
          if (rx_cnt_q == 16'h0000)
          begin
            // framing error drops the byte
            rx_push_q <= rx_s_q[1];
            rx_st_q   <= SBL_RX_IDLE;
          end
          else
          begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  sbl_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (rx_push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_sh_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // -----------------------------------------------------------------
  // serial transmitter
  // -----------------------------------------------------------------
  logic [9:0]  tx_sh_q;
  logic [3:0]  tx_n_q;
  logic [15:0] tx_cnt_q;
  logic        tx_busy_q;
  logic        tx_go_q;
  logic [7:0]  tx_byte_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      tx_sh_q   <= 10'h3ff;
      tx_n_q    <= 4'h0;
      tx_cnt_q  <= 16'h0000;
      tx_busy_q <= 1'b0;
      txd_q     <= 1'b1;
    end
    else
    begin
      txd_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (!tx_busy_q && tx_go_q)
      begin
        tx_sh_q   <= {1'b1, tx_byte_q, 1'b0};
        tx_n_q    <= 4'(FRAME_BITS);
        tx_cnt_q  <= 16'(BIT_CYCLES - 1);
        tx_busy_q <= 1'b1;
      end
      else if (tx_busy_q)
      begin
        if (tx_cnt_q == 16'h0000)
        begin
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_cnt_q <= 16'(BIT_CYCLES - 1);
          tx_n_q   <= tx_n_q - 4'h1;
          if (tx_n_q == 4'h1)
          begin
            tx_busy_q <= 1'b0;
          end
        end
        else
        begin
          tx_cnt_q <= tx_cnt_q - 16'h0001;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // block sequencer
  // -----------------------------------------------------------------
  sbl_st_t    st_q;
  sbl_eng_t   eng_q;
  logic [7:0] blk_q  [HDR_BYTES + BLOCK_BYTES];
  logic [7:0] echo_q [BLOCK_BYTES];
  logic [7:0] res_q  [BLOCK_BYTES];
  logic [2:0] e_q;
  logic [2:0] r_q;
  logic [1:0] boot_q;
  logic       eng_go_q;
  logic       par_wr_q;
  logic [7:0] par_wdata_q;
  logic       eng_free;

  assign fifo_pop = (st_q == SBL_RX) && fifo_out_valid;
  assign eng_free = !eng_go_q && (eng_q == SBL_E_IDLE);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st_q                <= SBL_BOOT;
      e_q                 <= 3'h0;
      r_q                 <= 3'h0;
      boot_q              <= 2'h0;
      eng_go_q            <= 1'b0;
      tx_go_q             <= 1'b0;
      tx_byte_q           <= 8'h00;
      exec_valid_q        <= 1'b0;
      exec_addr_q         <= 16'h0000;
      handshake_out_pin_q <= 1'b0;
      par_addr_q          <= 16'h0000;
      par_wr_q            <= 1'b0;
      par_wdata_q         <= 8'h00;
      pseudo_vec_active_q <= 1'b0;
      for (int k = 0; k < HDR_BYTES + BLOCK_BYTES; k++)
      begin
        blk_q[k] <= 8'h00;
      end
      for (int k = 0; k < BLOCK_BYTES; k++)
      begin
        echo_q[k] <= 8'h00;
      end
    end
    else
    begin
      tx_go_q  <= 1'b0;
      eng_go_q <= 1'b0;
      par_wr_q <= 1'b0;
      unique case (st_q)
        SBL_BOOT:
        begin
          // straps caught once the synchronisers hold post-release levels
          boot_q <= boot_q + 2'h1;
          if (boot_q == 2'(STRAP_SETTLE))
          begin
            if (m3_s_q[1] && m4_s_q[1])
            begin
              eng_go_q            <= 1'b1;
              pseudo_vec_active_q <= 1'b1;
              st_q                <= SBL_INIT;
            end
            else if (!m3_s_q[1] && m4_s_q[1])
            begin
              par_addr_q          <= PAR_ENTRY;
              pseudo_vec_active_q <= 1'b1;
              st_q                <= SBL_PREQ;
            end
            else
            begin
              st_q <= SBL_HALT;
            end
          end
        end
        SBL_INIT:
        begin
          if (eng_free)
          begin
            echo_q <= res_q;
            st_q   <= SBL_NEXT;
          end
        end
        SBL_NEXT:
        begin
          if (e_q == r_q && e_q < 3'(BLOCK_BYTES))
          begin
            st_q <= SBL_TX;
          end
          else if (r_q < 3'(HDR_BYTES + BLOCK_BYTES))
          begin
            st_q <= SBL_RX;
          end
          else
          begin
            st_q <= SBL_END;
          end
        end
        SBL_TX:
        begin
          if (!tx_busy_q && !tx_go_q)
          begin
            tx_byte_q <= echo_q[e_q[1:0]];
            tx_go_q   <= 1'b1;
            e_q       <= e_q + 3'h1;
            st_q      <= SBL_NEXT;
          end
        end
        SBL_RX:
        begin
          if (fifo_out_valid)
          begin
            blk_q[r_q] <= fifo_out_data;
            if (r_q == 3'h0 && fifo_out_data[EXEC_BIT])
            begin
              st_q <= SBL_EXEC;
            end
            else
            begin
              r_q  <= r_q + 3'h1;
              st_q <= SBL_NEXT;
            end
          end
        end
        SBL_END:
        begin
          // echo of block n-1 goes out while block n is programmed
          if (eng_free)
          begin
            echo_q   <= res_q;
            eng_go_q <= 1'b1;
            e_q      <= 3'h0;
            r_q      <= 3'h0;
            st_q     <= SBL_NEXT;
          end
        end
        SBL_PREQ:
        begin
          if (!stop_s_q[1] || par_addr_q > RAM_TOP)
          begin
            exec_addr_q  <= PAR_ENTRY;
            exec_valid_q <= 1'b1;
            st_q         <= SBL_HALT;
          end
          else
          begin
            handshake_out_pin_q <= 1'b1;
            st_q                <= SBL_PACK;
          end
        end
        SBL_PACK:
        begin
          if (hs_s_q[1])
          begin
            par_wdata_q         <= pd_s2_q;
            par_wr_q            <= 1'b1;
            handshake_out_pin_q <= 1'b0;
            st_q                <= SBL_PREL;
          end
        end
        SBL_PREL:
        begin
          if (!hs_s_q[1])
          begin
            par_addr_q <= par_addr_q + 16'h0001;
            st_q       <= SBL_PREQ;
          end
        end
        SBL_EXEC:
        begin
          if (eng_free)
          begin
            exec_addr_q  <= EXEC_ENTRY;
            exec_valid_q <= 1'b1;
            st_q         <= SBL_HALT;
          end
        end
        SBL_HALT:
        begin
          st_q <= SBL_HALT;
        end
        default:
        begin
          st_q <= SBL_HALT;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // programming engine and memory port
  // -----------------------------------------------------------------
  logic [15:0] base_q;
  logic [7:0]  data_q [BLOCK_BYTES];
  logic [1:0]  i_q;
  logic        wrote_q;
  logic        in_ram_q;
  logic [31:0] pcnt_q;
  logic [15:0] blk_base;
  logic [15:0] cur_addr;
  logic        blk_ram;
  logic        user_ok;

  assign blk_base = {blk_q[0], blk_q[1][7:2], 2'b00};
  assign blk_ram  = (blk_base >= RAM_BASE) && (blk_base <= RAM_TOP);
  assign cur_addr = base_q + {14'h0000, i_q};
  // loader workspace and stack stay untouched by serial user data
  assign user_ok  = !(cur_addr >= LDR_LO && cur_addr <= LDR_HI)
                    && (cur_addr <= RAM_TOP - STACK_BYTES);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      eng_q                  <= SBL_E_IDLE;
      base_q                 <= 16'h0000;
      i_q                    <= 2'h0;
      wrote_q                <= 1'b0;
      in_ram_q               <= 1'b0;
      pcnt_q                 <= 32'h0000_0000;
      mem_addr_q             <= 16'h0000;
      mem_wdata_q            <= 8'h00;
      eprom_we_q             <= 1'b0;
      ram_we_q               <= 1'b0;
      program_latch_enable_q <= 1'b0;
      program_enable_q       <= 1'b0;
      red_led_q              <= 1'b0;
      for (int k = 0; k < BLOCK_BYTES; k++)
      begin
        data_q[k] <= 8'h00;
        res_q[k]  <= 8'h00;
      end
    end
    else
    begin
      eprom_we_q <= 1'b0;
      ram_we_q   <= 1'b0;
      unique case (eng_q)
        SBL_E_IDLE:
        begin
          if (par_wr_q)
          begin
            mem_addr_q  <= par_addr_q;
            mem_wdata_q <= par_wdata_q;
            ram_we_q    <= 1'b1;
          end
          else if (eng_go_q)
          begin
            base_q   <= blk_base;
            in_ram_q <= blk_ram;
            wrote_q  <= 1'b0;
            i_q      <= 2'h0;
            for (int k = 0; k < BLOCK_BYTES; k++)
            begin
              data_q[k] <= blk_q[HDR_BYTES + k];
            end
            eng_q <= blk_ram ? SBL_E_WR : SBL_E_LATCH;
          end
        end
        SBL_E_LATCH:
        begin
          program_latch_enable_q <= 1'b1;
          eng_q                  <= SBL_E_WR;
        end
        SBL_E_WR:
        begin
          if (data_q[i_q] != 8'h00)
          begin
            mem_addr_q  <= cur_addr;
            mem_wdata_q <= data_q[i_q];
            if (in_ram_q)
            begin
              ram_we_q <= user_ok;
            end
            else
            begin
              eprom_we_q <= 1'b1;
              wrote_q    <= 1'b1;
            end
          end
          i_q <= i_q + 2'h1;
          if (i_q == 2'h3)
          begin
            pcnt_q <= 32'(PROG_CNT - 1);
            eng_q  <= SBL_E_PGM;
          end
        end
        SBL_E_PGM:
        begin
          // enable only with latch held and at least one byte latched
          if (!in_ram_q && wrote_q && program_latch_enable_q)
          begin
            program_enable_q <= 1'b1;
            if (pcnt_q == 32'h0000_0000)
            begin
              eng_q <= SBL_E_CLR;
            end
            else
            begin
              pcnt_q <= pcnt_q - 32'h0000_0001;
            end
          end
          else
          begin
            eng_q <= SBL_E_CLR;
          end
        end
        SBL_E_CLR:
        begin
          program_latch_enable_q <= 1'b0;
          program_enable_q       <= 1'b0;
          i_q                    <= 2'h0;
          eng_q                  <= SBL_E_RA;
        end
        SBL_E_RA:
        begin
          mem_addr_q <= cur_addr;
          eng_q      <= SBL_E_RD;
        end
        SBL_E_RD:
        begin
          res_q[i_q] <= mem_rdata;
          red_led_q  <= (mem_rdata != 8'h00);
          i_q        <= i_q + 2'h1;
          eng_q      <= (i_q == 2'h3) ? SBL_E_IDLE : SBL_E_RA;
        end
        default:
        begin
          eng_q <= SBL_E_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // pseudo-vector redirection
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      vec_target_q <= VEC_BASE;
    end
    else if (vec_idx < VEC_COUNT)
    begin
      vec_target_q <= VEC_BASE + 16'({13'h0000, vec_idx} * VEC_STEP);
    end
    else
    begin
      vec_target_q <= VEC_BASE;
    end
  end

endmodule

// [src/sbl_pkg.sv]
// Purpose: shared constants of the serial bootstrap loader
// Assumes: 10 MHz core clock, 8N1 serial link
// Notes:   addresses are 16-bit core addresses
package sbl_pkg;

  // ---------------------------------------------------------------
  // clock and link timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int BAUD         = 9600;
  localparam int BIT_CYCLES   = CLK_HZ / BAUD;
  localparam int HALF_BIT     = BIT_CYCLES / 2;
  localparam int FRAME_BITS   = 10;
  localparam int DATA_W       = 8;

  // ---------------------------------------------------------------
  // programming time (least time, rounded up)
  // ---------------------------------------------------------------
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES  = (PROG_TIME_US * (CLK_HZ / 1000) + 999) / 1000;

  // ---------------------------------------------------------------
  // block format, receive buffer depth and strap settle count
  // ---------------------------------------------------------------
  localparam int HDR_BYTES    = 2;
  localparam int BLOCK_BYTES  = 4;
  localparam int EXEC_BIT     = 7;
  localparam int FIFO_DEPTH   = 16;
  localparam int STRAP_SETTLE = 3;

  // ---------------------------------------------------------------
  // memory map
  // ---------------------------------------------------------------
  localparam logic [15:0] EXEC_ENTRY   = 16'h0083;
  localparam logic [15:0] PAR_ENTRY    = 16'h0050;
  localparam logic [15:0] LDR_LO       = 16'h0050;
  localparam logic [15:0] LDR_HI       = 16'h0082;
  localparam logic [15:0] RAM_BASE_DEF = 16'h0050;
  localparam logic [15:0] RAM_TOP_DEF  = 16'h00ff;
  localparam logic [15:0] STACK_BYTES  = 16'h000a;
  localparam logic [15:0] VEC_BASE     = 16'h00e4;
  localparam logic [15:0] VEC_STEP     = 16'h0003;
  localparam logic [2:0]  VEC_COUNT    = 3'h6;

endpackage

// [src/sbl_fifo.sv]
// Purpose: receive byte buffer between serial receiver and loader
// Assumes: single clock, synchronous active-low reset
// Notes:   one pointer bit extra distinguishes full from empty
module sbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// [dv/sbl_loader_properties.sv]
// Purpose: port-level properties of the loader
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every loader instance
module sbl_loader_properties #(
  parameter logic [15:0] RAM_BASE = 16'h0050,
  parameter logic [15:0] RAM_TOP  = 16'h00ff
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // loader outputs and vector index
  input wire logic        txd_q,
  input wire logic        handshake_out_pin_q,
  input wire logic [15:0] mem_addr_q,
  input wire logic [7:0]  mem_wdata_q,
  input wire logic        eprom_we_q,
  input wire logic        ram_we_q,
  input wire logic        program_latch_enable_q,
  input wire logic        program_enable_q,
  input wire logic        exec_valid_q,
  input wire logic [15:0] exec_addr_q,
  input wire logic [2:0]  vec_idx,
  input wire logic [15:0] vec_target_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_pgm_latch; program_enable_q |-> program_latch_enable_q; endproperty
  a_pgm_latch: assert property (p_pgm_latch) else $error("program without latch");
  property p_latch_drop; $fell(program_latch_enable_q) |-> !program_enable_q; endproperty
  a_latch_drop: assert property (p_latch_drop) else $error("program left on");
  property p_we_latched; eprom_we_q |-> program_latch_enable_q && !program_enable_q; endproperty
  a_we_latched: assert property (p_we_latched) else $error("write outside latch phase");
  property p_we_nonzero; eprom_we_q |-> mem_wdata_q != 8'h00; endproperty
  a_we_nonzero: assert property (p_we_nonzero) else $error("zero byte written");
  property p_ram_range; ram_we_q |-> mem_addr_q >= RAM_BASE && mem_addr_q <= RAM_TOP; endproperty
  a_ram_range: assert property (p_ram_range) else $error("ram write outside ram");
  property p_vec; vec_idx < 3'h6 |=> vec_target_q == 16'h00e4 + 16'h0003 * 16'($past(vec_idx)); endproperty
  a_vec: assert property (p_vec) else $error("bad vector slot");
  property p_exec_hold; exec_valid_q |=> exec_valid_q && $stable(exec_addr_q); endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("hand-over not held");
  property p_exec_addr; exec_valid_q |-> exec_addr_q == 16'h0083 || exec_addr_q == 16'h0050; endproperty
  a_exec_addr: assert property (p_exec_addr) else $error("bad entry address");
  property p_hs_stop; exec_valid_q |-> !handshake_out_pin_q; endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("request after hand-over");
  property p_start_bit; $fell(txd_q) |=> !txd_q [*8]; endproperty
  a_start_bit: assert property (p_start_bit) else $error("short start bit");
  c_ram: cover property (ram_we_q);
  c_exec: cover property ($rose(exec_valid_q));
  c_tx: cover property ($fell(txd_q));
endmodule
bind sbl_loader sbl_loader_properties #(.RAM_BASE(RAM_BASE), .RAM_TOP(RAM_TOP)) chk_u (.sys_clk, .rst_b,
  .txd_q, .handshake_out_pin_q, .mem_addr_q, .mem_wdata_q, .eprom_we_q, .ram_we_q, .program_latch_enable_q,
  .program_enable_q, .exec_valid_q, .exec_addr_q, .vec_idx, .vec_target_q);

// [dv/sbl_host_model.sv]
// Purpose: serial host on the far side of the link
// Assumes: 8N1 at the package bit time
// Notes:   raw binary bytes, lsb first
module sbl_host_model (
  // clock
  input wire logic sys_clk,
  // serial link
  input wire logic txd_q,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  import sbl_pkg::*;
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < FRAME_BITS; i++)
    begin
      @(posedge sys_clk) #1 rxd = frame[i];
      repeat (BIT_CYCLES - 1) @(posedge sys_clk);
    end
  endtask
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (txd_q !== 1'b0 && n < 40000)
    begin
      @(posedge sys_clk);
      n++;
    end
    // sample mid-bit; a silent device leaves ok low
    if (n < 40000)
    begin
      repeat (HALF_BIT + BIT_CYCLES) @(posedge sys_clk);
      for (int i = 0; i < DATA_W; i++)
      begin
        b[i] = txd_q;
        repeat (BIT_CYCLES) @(posedge sys_clk);
      end
      ok = (txd_q === 1'b1);
    end
  endtask
endmodule

// [dv/serial_bootstrap_loader_test.sv]
// Purpose: parallel and serial load scenarios
// Assumes: memory reads return addr low byte plus 0x11
// Notes:   handshake pins tied together
module serial_bootstrap_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sbl_pkg::*;
  logic sys_clk, rst_b, mode_select_bit_three, mode_select_bit_four, load_stop_pin, rxd, txd_q, ok;
  logic handshake_out_pin_q, eprom_we_q, ram_we_q, program_latch_enable_q, program_enable_q;
  logic red_led_q, exec_valid_q, pseudo_vec_active_q;
  logic [7:0] par_data, mem_rdata, mem_wdata_q, rx_byte;
  logic [15:0] par_addr_q, mem_addr_q, exec_addr_q, vec_target_q, next_addr;
  logic [2:0] vec_idx;
  logic [15:0] slots [6] = '{16'h00e4, 16'h00e7, 16'h00ea, 16'h00ed, 16'h00f0, 16'h00f3};
  int errors, comparisons, writes;
  sbl_loader #(.PROG_CNT(20)) dut_u (.sys_clk, .rst_b, .mode_select_bit_three, .mode_select_bit_four,
    .load_stop_pin, .rxd, .txd_q, .par_data, .handshake_in_pin(handshake_out_pin_q), .handshake_out_pin_q,
    .par_addr_q, .mem_rdata, .mem_addr_q, .mem_wdata_q, .eprom_we_q, .ram_we_q, .program_latch_enable_q,
    .program_enable_q, .red_led_q, .exec_valid_q, .exec_addr_q, .vec_idx, .pseudo_vec_active_q, .vec_target_q);
  sbl_host_model host_u (.sys_clk, .txd_q, .rxd);
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // read data must stand at the edge after the address, so no register here
  assign mem_rdata = mem_addr_q[7:0] + 8'h11;
  always @(posedge sys_clk)
    if (eprom_we_q === 1'b1)
    begin
      check_val({mem_addr_q[15:2], 2'b00}, 16'h0100);
      check_val({8'h00, mem_wdata_q}, 16'h0031 + 16'(mem_addr_q[1:0]));
      writes++;
    end
  always @(posedge sys_clk) par_data <= par_addr_q[7:0] ^ 8'ha5;
  always @(posedge sys_clk)
    if (ram_we_q === 1'b1)
    begin
      check_val({8'h00, mem_wdata_q}, {8'h00, next_addr[7:0] ^ 8'ha5});
      check_val(mem_addr_q, next_addr);
      next_addr <= next_addr + 16'h0001;
    end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset(input logic s3, input logic s4);
    @(posedge sys_clk) #1 rst_b = 1'b0;
    mode_select_bit_three = s3;
    mode_select_bit_four = s4;
    load_stop_pin = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst_b = 1'b1;
  endtask
  task automatic wait_exec(input logic [15:0] exp);
    for (int n = 0; n < 2000 && exec_valid_q !== 1'b1; n++) @(posedge sys_clk);
    #1 check_val({15'h0000, exec_valid_q}, 16'h0001);
    check_val(exec_addr_q, exp);
    if (exec_valid_q !== 1'b1) tally_and_finish();
  endtask
  initial
  begin
    {errors, comparisons, writes, vec_idx, par_data} = '0;
    next_addr = 16'h0050;
    rst_b = 1'b0;
    // ------------------------------------------------
    // parallel ram load, stopped by the pin
    // ------------------------------------------------
    do_reset(1'b0, 1'b1);
    for (int n = 0; n < 500 && next_addr != 16'h0056; n++) @(posedge sys_clk);
    check_val(next_addr, 16'h0056);
    if (next_addr != 16'h0056) tally_and_finish();
    #1 load_stop_pin = 1'b0;
    wait_exec(16'h0050);
    check_val({15'h0000, pseudo_vec_active_q}, 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      vec_idx = 3'(i);
      repeat (2) @(posedge sys_clk);
      #1 check_val(vec_target_q, slots[i]);
    end
    // ------------------------------------------------
    // serial: prompt, one eprom block, then execute request
    // ------------------------------------------------
    do_reset(1'b1, 1'b1);
    fork
      host_u.get_byte(rx_byte, ok);
      begin
        // host runs ahead of the prompts once the first has started
        repeat (200) @(posedge sys_clk);
        host_u.send_byte(8'h01);
        host_u.send_byte(8'h00);
        host_u.send_byte(8'h31);
        host_u.send_byte(8'h00);
        host_u.send_byte(8'h33);
        host_u.send_byte(8'h34);
        host_u.send_byte(8'h80);
      end
    join
    check_val({15'h0000, ok}, 16'h0001);
    check_val({8'h00, rx_byte}, 16'h0011);
    check_val({15'h0000, red_led_q}, 16'h0001);
    if (ok !== 1'b1) tally_and_finish();
    wait_exec(16'h0083);
    check_val(16'(writes), 16'h0003);
    tally_and_finish();
  end
endmodule
